// ---- shared/pin_change_map.svh ----
`ifndef PIN_CHANGE_MAP_SVH
`define PIN_CHANGE_MAP_SVH

// register byte offsets on the axi4-lite bus
`define OFS_RISE_EDGE_ENABLE 12'h000
`define OFS_FALL_EDGE_ENABLE 12'h004
`define OFS_PIN_CHANGE_FLAG 12'h008
`define OFS_CHANGE_CONTROL 12'h00C
`define OFS_PIN_LEVEL 12'h010

// field positions inside the control register
`define BIT_CHANGE_SUMMARY_FLAG 0
`define BIT_CHANGE_IRQ_ENABLE 1

// reset values
`define RST_BYTE 8'h00
`define RST_WORD 32'h0000_0000

// axi response codes
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ---- shared/pin_change_pkg.sv ----
package pin_change_pkg;
    // write-channel states of the bus slave
    typedef enum logic [2:0] {
        wr_idle = 3'b001,
        wr_resp = 3'b010,
        wr_hold = 3'b100
    } wr_state_e;
    // read-channel states of the bus slave
    typedef enum logic [1:0] {
        rd_idle = 2'b01,
        rd_data = 2'b10
    } rd_state_e;
endpackage

// ---- hdl/pin_sync_edge.sv ----
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser per pin plus a history flop for edge detection
module pin_sync_edge #(
    parameter int WIDTH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [WIDTH-1:0] pin_async,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] meta; // first stage, read only by the second
    logic [WIDTH-1:0] sync; // second stage, safe to use
    logic [WIDTH-1:0] hist; // previous synchronised level
    logic [2:0] warm; // marks stages that hold real pin samples

    // elaboration-time refusal of an empty port
    if (WIDTH < 1) begin : g_bad_width
        $error("pin_sync_edge needs at least one pin");
    end

    // all stages register together; edges stay masked until the
    // history flop holds a real sample, so a pin that idles high
    // after reset is not mistaken for a rising edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= '0;
            sync <= '0;
            hist <= '0;
            warm <= '0;
        end else if (ce) begin
            meta <= pin_async;
            sync <= meta;
            hist <= sync;
            warm <= {warm[1:0], 1'b1};
        end
    end

    // edge terms are combinational on the settled stages only
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_edge
            assign rise[i] = sync[i] & ~hist[i] & warm[2];
            assign fall[i] = ~sync[i] & hist[i] & warm[2];
        end
    endgenerate
    assign level = sync;
endmodule
`default_nettype wire

// ---- hdl/port_pin_change_detect.sv ----
//Contract
//- rising enable 1 makes rising edges events
//- falling enable 1 makes falling edges events
//- enable 0 suppresses that edge direction
//- enabled edge sets the pin change flag
//- any enabled edge sets summary flag too
//- software clears flags; new edge sets again
//- enables and flags reset to zero
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pin_change_map.svh"
module port_pin_change_detect
    import pin_change_pkg::*;
#(
    parameter int PINS = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [PINS-1:0] port_pin,
    output logic change_irq,
    // axi4-lite slave
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // registers are byte wide and live in byte lane 0
    if (PINS < 1 || PINS > 8) begin : g_bad_pins
        $error("port_pin_change_detect supports 1 to 8 pins");
    end

    logic [PINS-1:0] pin_level; // synchronised watched_port level
    logic [PINS-1:0] pin_rise; // one-cycle rise pulses
    logic [PINS-1:0] pin_fall; // one-cycle fall pulses

    // pins cross into aclk through two flops before any edge logic
    pin_sync_edge #(
        .WIDTH(PINS)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .pin_async(port_pin),
        .level(pin_level),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    logic [PINS-1:0] rise_edge_enable; // per-pin rising enable
    logic [PINS-1:0] fall_edge_enable; // per-pin falling enable
    logic [PINS-1:0] pin_change_flag; // sticky per-pin flags
    logic change_summary_flag; // sticky summary flag
    logic change_irq_enable; // gates the request output
    logic [PINS-1:0] next_rise_edge_enable;
    logic [PINS-1:0] next_fall_edge_enable;
    logic [PINS-1:0] next_pin_change_flag;
    logic next_change_summary_flag;
    logic next_change_irq_enable;
    logic next_change_irq;
    logic [PINS-1:0] edge_event; // qualified change events

    // write channel state
    wr_state_e wr_state, next_wr_state;
    logic [11:0] wr_addr, next_wr_addr;
    logic [31:0] wr_data, next_wr_data;
    logic [3:0] wr_strb, next_wr_strb;
    logic aw_got, next_aw_got; // address captured
    logic w_got, next_w_got; // data captured
    logic awready_q, next_awready;
    logic wready_q, next_wready;
    logic bvalid_q, next_bvalid;
    logic [1:0] bresp_q, next_bresp;
    logic wr_fire; // one-cycle register write
    logic wr_hit; // address decodes to a register
    // read channel state
    rd_state_e rd_state, next_rd_state;
    logic arready_q, next_arready;
    logic rvalid_q, next_rvalid;
    logic [31:0] rdata_q, next_rdata;
    logic [1:0] rresp_q, next_rresp;

    // edge qualification per pin
    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_evt
            assign edge_event[g] =
                (pin_rise[g] & rise_edge_enable[g]) |
                (pin_fall[g] & fall_edge_enable[g]);
        end
    endgenerate

    // address decode for writes
    always_comb begin
        wr_hit = 1'b0;
        case (wr_addr)
            `OFS_RISE_EDGE_ENABLE: wr_hit = 1'b1;
            `OFS_FALL_EDGE_ENABLE: wr_hit = 1'b1;
            `OFS_PIN_CHANGE_FLAG: wr_hit = 1'b1;
            `OFS_CHANGE_CONTROL: wr_hit = 1'b1;
            `OFS_PIN_LEVEL: wr_hit = 1'b1; // read-only, write ignored
            default: wr_hit = 1'b0;
        endcase
    end

    // next values of the block's own registers
    always_comb begin
        next_rise_edge_enable = rise_edge_enable;
        next_fall_edge_enable = fall_edge_enable;
        next_pin_change_flag = pin_change_flag;
        next_change_summary_flag = change_summary_flag;
        next_change_irq_enable = change_irq_enable;
        // software writes first, so a same-cycle edge overrides a clear
        if (wr_fire && wr_strb[0]) begin
            case (wr_addr)
                `OFS_RISE_EDGE_ENABLE: begin
                    next_rise_edge_enable = wr_data[PINS-1:0];
                end
                `OFS_FALL_EDGE_ENABLE: begin
                    next_fall_edge_enable = wr_data[PINS-1:0];
                end
                `OFS_PIN_CHANGE_FLAG: begin
                    // plain write lets software clear flags to 0
                    next_pin_change_flag = wr_data[PINS-1:0];
                end
                `OFS_CHANGE_CONTROL: begin
                    next_change_summary_flag =
                        wr_data[`BIT_CHANGE_SUMMARY_FLAG];
                    next_change_irq_enable =
                        wr_data[`BIT_CHANGE_IRQ_ENABLE];
                end
                default: begin
                end
            endcase
        end
        // hardware set wins over any clear in the same cycle
        next_pin_change_flag = next_pin_change_flag | edge_event;
        if (|edge_event) begin
            next_change_summary_flag = 1'b1;
        end
        // request follows the stored flag and enable
        next_change_irq = next_change_summary_flag &
            next_change_irq_enable;
    end

    // block registers; every reset clears enables and flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rise_edge_enable <= `RST_BYTE;
            fall_edge_enable <= `RST_BYTE;
            pin_change_flag <= `RST_BYTE;
            change_summary_flag <= 1'b0;
            change_irq_enable <= 1'b0;
            change_irq <= 1'b0;
        end else if (ce) begin
            rise_edge_enable <= next_rise_edge_enable;
            fall_edge_enable <= next_fall_edge_enable;
            pin_change_flag <= next_pin_change_flag;
            change_summary_flag <= next_change_summary_flag;
            change_irq_enable <= next_change_irq_enable;
            change_irq <= next_change_irq;
        end
    end

    // write channel: take aw and w in either order, then answer
    always_comb begin
        next_wr_state = wr_state;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        next_wr_strb = wr_strb;
        next_aw_got = aw_got;
        next_w_got = w_got;
        next_awready = 1'b0;
        next_wready = 1'b0;
        next_bvalid = bvalid_q;
        next_bresp = bresp_q;
        wr_fire = 1'b0;
        case (wr_state)
            wr_idle: begin
                if (s_axi_awvalid && awready_q) begin
                    next_aw_got = 1'b1;
                    next_wr_addr = s_axi_awaddr;
                end
                if (s_axi_wvalid && wready_q) begin
                    next_w_got = 1'b1;
                    next_wr_data = s_axi_wdata;
                    next_wr_strb = s_axi_wstrb;
                end
                // ready is offered one cycle, then withdrawn
                next_awready = !next_aw_got && !awready_q;
                next_wready = !next_w_got && !wready_q;
                // both readys are already low once both halves are held
                if (next_aw_got && next_w_got) begin
                    next_wr_state = wr_hold;
                end
            end
            wr_hold: begin
                // captured pair is applied here, one cycle
                wr_fire = wr_hit;
                next_bresp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
                next_bvalid = 1'b1;
                next_wr_state = wr_resp;
            end
            wr_resp: begin
                if (s_axi_bready) begin
                    next_bvalid = 1'b0;
                    next_aw_got = 1'b0;
                    next_w_got = 1'b0;
                    next_wr_state = wr_idle;
                end
            end
            default: begin
                next_wr_state = wr_idle;
            end
        endcase
    end

    // write channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state <= wr_idle;
            wr_addr <= 12'h000;
            wr_data <= `RST_WORD;
            wr_strb <= 4'h0;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
        end else if (ce) begin
            wr_state <= next_wr_state;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
            wr_strb <= next_wr_strb;
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            awready_q <= next_awready;
            wready_q <= next_wready;
            bvalid_q <= next_bvalid;
            bresp_q <= next_bresp;
        end
    end

    // read channel: one-cycle ready pulse, data registered
    always_comb begin
        next_rd_state = rd_state;
        next_arready = 1'b0;
        next_rvalid = rvalid_q;
        next_rdata = rdata_q;
        next_rresp = rresp_q;
        case (rd_state)
            rd_idle: begin
                next_arready = s_axi_arvalid && !arready_q;
                if (s_axi_arvalid && arready_q) begin
                    next_rvalid = 1'b1;
                    next_rresp = `RESP_OKAY;
                    next_rdata = `RST_WORD;
                    case (s_axi_araddr)
                        `OFS_RISE_EDGE_ENABLE: begin
                            next_rdata[PINS-1:0] = rise_edge_enable;
                        end
                        `OFS_FALL_EDGE_ENABLE: begin
                            next_rdata[PINS-1:0] = fall_edge_enable;
                        end
                        `OFS_PIN_CHANGE_FLAG: begin
                            next_rdata[PINS-1:0] = pin_change_flag;
                        end
                        `OFS_CHANGE_CONTROL: begin
                            next_rdata[`BIT_CHANGE_SUMMARY_FLAG] =
                                change_summary_flag;
                            next_rdata[`BIT_CHANGE_IRQ_ENABLE] =
                                change_irq_enable;
                        end
                        `OFS_PIN_LEVEL: begin
                            next_rdata[PINS-1:0] = pin_level;
                        end
                        default: begin
                            next_rresp = `RESP_SLVERR;
                        end
                    endcase
                    next_rd_state = rd_data;
                end
            end
            rd_data: begin
                if (s_axi_rready) begin
                    next_rvalid = 1'b0;
                    next_rd_state = rd_idle;
                end
            end
            default: begin
                next_rd_state = rd_idle;
            end
        endcase
    end

    // read channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state <= rd_idle;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= `RST_WORD;
            rresp_q <= `RESP_OKAY;
        end else if (ce) begin
            rd_state <= next_rd_state;
            arready_q <= next_arready;
            rvalid_q <= next_rvalid;
            rdata_q <= next_rdata;
            rresp_q <= next_rresp;
        end
    end
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
endmodule
`default_nettype wire

// ---- verification/pin_change_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// watches the port block from its pins and bus only
module pin_change_checker #(
    parameter int PINS = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [PINS-1:0] port_pin,
    input wire logic change_irq,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [PINS-1:0] last_pin; // pin level seen at the previous edge
    logic [3:0] quiet; // edges with ce high since the pins last moved, saturating

    // count quiet edges so an interrupt can be traced to a pin change
    always_ff @(posedge aclk) begin
        last_pin <= port_pin;
        if (!aresetn || port_pin != last_pin) begin
            quiet <= 4'h0;
        end else if (ce && quiet != 4'hF) begin
            quiet <= quiet + 4'h1;
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_reset_quiet: assert property (
        $rose(aresetn) |-> !change_irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not idle after reset");
    // irq may only rise from a synced pin edge or a register write
    chk_irq_rise_cause: assert property (
        $rose(change_irq) |-> s_axi_bvalid || (quiet >= 1 && quiet <= 6))
        else $error("interrupt rose without cause");
    chk_irq_fall_cause: assert property (
        $fell(change_irq) |-> $rose(s_axi_bvalid))
        else $error("interrupt dropped without a write");
    chk_read_turn: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_write_turn: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    chk_rvalid_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    chk_bvalid_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    chk_ce_freeze: assert property (
        $changed(change_irq) |-> $past(ce))
        else $error("interrupt moved while frozen");
endmodule

bind port_pin_change_detect pin_change_checker #(.PINS(PINS)) u_chk (
    .aclk, .aresetn, .ce, .port_pin, .change_irq, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

// ---- verification/pin_source.sv ----
`timescale 1ns/1ps
`default_nettype none
// outside world driving the watched port; lag makes it slow to follow
module pin_source (
    input wire logic aclk,
    input wire logic [7:0] target,
    input wire logic [3:0] lag,
    output logic [7:0] port_pin
);
    logic [3:0] wait_cnt; // edges spent waiting on a pending move

    initial begin
        port_pin = 8'h00;
        wait_cnt = 4'h0;
    end

    // pins move all at once, lag+1 edges after the target changes
    always @(posedge aclk) begin
        if (target == port_pin) begin
            wait_cnt <= 4'h0;
        end else if (wait_cnt >= lag) begin
            port_pin <= target;
            wait_cnt <= 4'h0;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pin_change_map.svh"
module testbench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0; // held low at start
    logic ce = 1'b1; // block kept running
    logic [7:0] pin_target = 8'h00; // level the pins head for
    logic [3:0] pin_lag = 4'h0; // 0 prompt, larger is a slow source
    logic [7:0] port_pin;
    logic change_irq;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF; // lane 0 strobe gates every write
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    int err_count = 0, samples_checked = 0;

    always #50 aclk = ~aclk;

    port_pin_change_detect u_dut (
        .aclk, .aresetn, .ce, .port_pin, .change_irq, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );
    pin_source u_pins (.aclk, .target(pin_target), .lag(pin_lag), .port_pin);

    task automatic close_out;
        if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // narrower results are zero-extended by the caller
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // bus response codes
    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // interrupt level as the block drives it
    task automatic check_irq(input logic exp);
        samples_checked++;
        if (change_irq !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, change_irq, exp);
        end
    endtask

    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    // bready rises only once bvalid is seen, so the hold is exercised
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
        check_resp(s_axi_bresp, er);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        check(d, {24'h0, e});
        check_resp(r, `RESP_OKAY);
    endtask

    // settle span covers sync, history and flag stages plus source lag
    task automatic move_pins(input logic [7:0] v);
        @(posedge aclk);
        pin_target <= v;
        repeat (12 + pin_lag) @(posedge aclk);
    endtask

    task automatic t_reset_values;
        check_irq(1'b0);
        rd_chk(`OFS_RISE_EDGE_ENABLE, `RST_BYTE);
        rd_chk(`OFS_FALL_EDGE_ENABLE, `RST_BYTE);
        rd_chk(`OFS_PIN_CHANGE_FLAG, `RST_BYTE);
        rd_chk(`OFS_CHANGE_CONTROL, `RST_BYTE);
    endtask

    // unmapped place: refused on both channels, nothing read back
    task automatic t_bus_refusal;
        logic [31:0] d;
        logic [1:0] r;
        wr(12'h020, 32'h0000_00FF, `RESP_SLVERR);
        rd(12'h020, d, r);
        check(d, 32'h0000_0000);
        check_resp(r, `RESP_SLVERR);
    endtask

    // low nibble watches rising edges, high nibble falling ones
    task automatic t_edges;
        wr(`OFS_RISE_EDGE_ENABLE, 32'h0000_000F, `RESP_OKAY);
        wr(`OFS_FALL_EDGE_ENABLE, 32'h0000_00F0, `RESP_OKAY);
        rd_chk(`OFS_RISE_EDGE_ENABLE, 8'h0F);
        rd_chk(`OFS_FALL_EDGE_ENABLE, 8'hF0);
        move_pins(8'hFF);
        rd_chk(`OFS_PIN_CHANGE_FLAG, 8'h0F);
        rd_chk(`OFS_CHANGE_CONTROL, 8'h01);
        rd_chk(`OFS_PIN_LEVEL, 8'hFF);
        wr(`OFS_PIN_LEVEL, 32'h0000_0000, `RESP_OKAY);
        rd_chk(`OFS_PIN_LEVEL, 8'hFF);
        s_axi_wstrb <= 4'h0; // lane 0 off: the enable must not move
        wr(`OFS_RISE_EDGE_ENABLE, 32'h0000_0000, `RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd_chk(`OFS_RISE_EDGE_ENABLE, 8'h0F);
        wr(`OFS_PIN_CHANGE_FLAG, 32'h0000_0000, `RESP_OKAY);
        wr(`OFS_CHANGE_CONTROL, 32'h0000_0000, `RESP_OKAY);
        rd_chk(`OFS_PIN_CHANGE_FLAG, 8'h00);
        rd_chk(`OFS_CHANGE_CONTROL, 8'h00);
        move_pins(8'h00);
        rd_chk(`OFS_PIN_CHANGE_FLAG, 8'hF0);
    endtask

    // slow source; flags stay sticky, interrupt follows summary and enable
    task automatic t_irq;
        pin_lag <= 4'h5;
        wr(`OFS_CHANGE_CONTROL, 32'h0000_0002, `RESP_OKAY);
        check_irq(1'b0);
        rd_chk(`OFS_CHANGE_CONTROL, 8'h02);
        move_pins(8'h01);
        check_irq(1'b1);
        rd_chk(`OFS_PIN_CHANGE_FLAG, 8'hF1);
        wr(`OFS_PIN_CHANGE_FLAG, 32'h0000_0000, `RESP_OKAY);
        wr(`OFS_CHANGE_CONTROL, 32'h0000_0002, `RESP_OKAY);
        check_irq(1'b0);
        move_pins(8'h81);
        check_irq(1'b0);
        move_pins(8'h01);
        check_irq(1'b1);
        rd_chk(`OFS_PIN_CHANGE_FLAG, 8'h80);
    endtask

    // frozen block ignores a pin move until its clock enable returns;
    // no bus traffic while frozen, since the slave would not answer
    task automatic t_freeze;
        wr(`OFS_PIN_CHANGE_FLAG, 32'h0000_0000, `RESP_OKAY);
        wr(`OFS_CHANGE_CONTROL, 32'h0000_0002, `RESP_OKAY);
        @(posedge aclk);
        ce <= 1'b0;
        move_pins(8'h03);
        check_irq(1'b0);
        ce <= 1'b1;
        repeat (6) @(posedge aclk);
        check_irq(1'b1);
        rd_chk(`OFS_PIN_CHANGE_FLAG, 8'h02);
    endtask

    initial begin
        do_reset();
        t_reset_values();
        t_bus_refusal();
        t_edges();
        t_irq();
        t_freeze();
        do_reset();
        t_reset_values();
        close_out();
    end

    // whole run needs well under a thousand edges
    initial begin
        repeat (5000) @(posedge aclk);
        err_count++;
        close_out();
    end
endmodule
`default_nettype wire
